// ===== src/gs_memory.sv
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps

// ==============================================================
// Command FIFO
// ==============================================================
module gs_fifo #(
    parameter int WIDTH = 49,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] buf_r [DEPTH];
    logic [AW-1:0] wr_idx_r;
    logic [AW-1:0] rd_idx_r;
    logic [AW:0] count_r;
    logic push;
    logic pop;

    // Flags come straight from the fill count
    assign in_ready = (count_r != FULL_COUNT);
    assign out_valid = (count_r != '0);
    assign out_data = buf_r[rd_idx_r];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Storage needs no reset; the count guards it
    always_ff @(posedge clk) begin
        if (push) begin
            buf_r[wr_idx_r] <= in_data;
        end
    end

    // Pointers wrap at depth, which need not be a power of two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_idx_r <= '0;
            rd_idx_r <= '0;
        end else begin
            if (push) begin
                wr_idx_r <= (wr_idx_r == LAST_IDX) ? '0 : wr_idx_r + 1'b1;
            end
            if (pop) begin
                rd_idx_r <= (rd_idx_r == LAST_IDX) ? '0 : rd_idx_r + 1'b1;
            end
        end
    end

    // Occupancy; a push and a pop in one cycle leave it unchanged.
    // Ready looks only at the count, so a full queue refuses a push
    // even in a cycle that pops: one cycle lost, a shorter ready path.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_r <= '0;
        end else if (push && !pop) begin
            count_r <= count_r + 1'b1;
        end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
        end
    end
endmodule // gs_fifo

// ==============================================================
// Double-bank grayscale memory
// ==============================================================
module double_bank_grayscale_memory
    import gs_memory_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [LINE_AW-1:0] DISP_LINE,
    input wire logic [UNIT_AW-1:0] DISP_UNIT,
    output logic [UNIT_W-1:0] DISP_DATA
);
    // ==========================================================
    // Declarations
    // ==========================================================
    logic ack_r;
    logic [31:0] dat_o_r;
    logic [UNIT_W-1:0] shift_r;
    logic [5:0] scan_num_r;
    logic hold_r;
    logic bank_sel_r;
    logic [UNIT_AW-1:0] unit_cnt_r;
    logic [LINE_AW-1:0] line_cnt_r;
    logic [UNIT_W-1:0] disp_data_r;
    logic [UNIT_W-1:0] mem_r [BANKS*LINES*UNITS_PER_LINE];
    logic [31:0] sel_mask;
    logic req;
    logic cmd_wr;
    logic cmd_known;
    logic cmd_is_sync;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FIFO_W-1:0] fifo_out_data;
    logic pop;
    logic pop_sync;
    logic gs_write;
    logic take;
    logic [31:0] rd_word;
    logic [MEM_AW-1:0] wr_addr;
    logic [MEM_AW-1:0] rd_addr;

    // ==========================================================
    // Bus decode
    // ==========================================================
    // A new request is one not yet answered. Masking with the ack
    // keeps a request that the master still holds in the ack cycle
    // from being taken a second time, which would push a command
    // twice into the queue.
    assign req = WB_CYC_I & WB_STB_I & ~ack_r;
    assign cmd_wr = req & WB_WE_I & (WB_ADR_I == OFS_COMMAND)
        & (WB_SEL_I[1:0] == 2'b11);
    assign cmd_known = (WB_DAT_I[15:0] == CMD_GS_WRITE)
        | (WB_DAT_I[15:0] == CMD_FRAME_SYNC);
    assign cmd_is_sync = (WB_DAT_I[15:0] == CMD_FRAME_SYNC);
    assign fifo_in_valid = cmd_wr & cmd_known;
    // A command held off by a full FIFO is not acked: back-pressure
    assign take = req & ~(fifo_in_valid & ~fifo_in_ready);

    // Byte lanes expanded to a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign sel_mask[gi*8 +: 8] = {8{WB_SEL_I[gi]}};
        end
    endgenerate

    // ==========================================================
    // Bus answer
    // ==========================================================
    // Ack one cycle after the request, dropped the cycle after
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= take;
        end
    end

    // Read mux; unmapped words read as zero
    always_comb begin
        rd_word = '0;
        if (WB_ADR_I == OFS_SHIFT_LO) begin
            rd_word = shift_r[31:0];
        end else if (WB_ADR_I == OFS_SHIFT_HI) begin
            rd_word[15:0] = shift_r[47:32];
        end else if (WB_ADR_I == OFS_CONFIG0) begin
            rd_word[SCAN_NUM_MSB:SCAN_NUM_LSB] = scan_num_r;
        end else if (WB_ADR_I == OFS_CONTROL) begin
            rd_word[CTRL_HOLD_BIT] = hold_r;
        end else if (WB_ADR_I == OFS_STATUS) begin
            rd_word[UNIT_AW-1:0] = unit_cnt_r;
            rd_word[STAT_LINE_LSB +: LINE_AW] = line_cnt_r;
            rd_word[STAT_NONEMPTY_BIT] = fifo_out_valid;
            rd_word[STAT_READY_BIT] = fifo_in_ready;
        end
    end

    // Read data registered with the ack
    // It holds until the next read, so a late look still finds it
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            dat_o_r <= '0;
        end else if (take && !WB_WE_I) begin
            dat_o_r <= rd_word;
        end
    end

    // ==========================================================
    // Software registers
    // ==========================================================
    // Common shift register, loaded by bytes
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            shift_r <= '0;
        end else if (take && WB_WE_I) begin
            if (WB_ADR_I == OFS_SHIFT_LO) begin
                shift_r[31:0] <= (shift_r[31:0] & ~sel_mask)
                    | (WB_DAT_I & sel_mask);
            end else if (WB_ADR_I == OFS_SHIFT_HI) begin
                shift_r[47:32] <= (shift_r[47:32] & ~sel_mask[15:0])
                    | (WB_DAT_I[15:0] & sel_mask[15:0]);
            end
        end
    end

    // Scan-line count field of the first config word
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            scan_num_r <= SCAN_NUM_RST;
        end else if (take && WB_WE_I && WB_ADR_I == OFS_CONFIG0
                     && WB_SEL_I[2]) begin
            scan_num_r <= WB_DAT_I[SCAN_NUM_MSB:SCAN_NUM_LSB];
        end
    end

    // Hold stalls the drain so queued commands can pile up
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            hold_r <= 1'b0;
        end else if (take && WB_WE_I && WB_ADR_I == OFS_CONTROL
                     && WB_SEL_I[0]) begin
            hold_r <= WB_DAT_I[CTRL_HOLD_BIT];
        end
    end

    // ==========================================================
    // Command queue
    // ==========================================================
    // Each entry is a sync flag and a copy of the shift register
    // Copying the shift register at the push lets software load the
    // next unit while earlier commands still wait in the queue.
    gs_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(CLOCK),
        .rst_n(RST_N),
        .in_valid(fifo_in_valid),
        .in_data({cmd_is_sync, shift_r}),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(~hold_r)
    );

    assign pop = fifo_out_valid & ~hold_r;
    assign pop_sync = pop & fifo_out_data[UNIT_W];
    assign gs_write = pop & ~fifo_out_data[UNIT_W];

    // ==========================================================
    // Bank selection
    // ==========================================================
    // Syncs travel through the same queue as the unit writes, so the
    // toggle lands only after every write queued ahead of it; the
    // roles never swap in the middle of a queued frame.
    // internal flag, not on the bus
    // clears to zero, bank A filled
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            bank_sel_r <= BANK_SEL_RST;
        end else if (pop_sync) begin
            bank_sel_r <= ~bank_sel_r;
        end
    end

    // ==========================================================
    // Fill counters
    // ==========================================================
    // A frame sync leaves both counters alone: the controller must
    // send whole frames, and a short frame shifts where the next one
    // starts. Status shows both counters so software can see it.
    // advance unit per write
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            unit_cnt_r <= '0;
            line_cnt_r <= '0;
        end else if (gs_write) begin
            if (unit_cnt_r == LAST_UNIT) begin
                unit_cnt_r <= '0;
                if (line_cnt_r == scan_num_r) begin
                    line_cnt_r <= '0;
                end else begin
                    line_cnt_r <= line_cnt_r + 1'b1;
                end
            end else begin
                unit_cnt_r <= unit_cnt_r + 1'b1;
            end
        end
    end

    // ==========================================================
    // Storage
    // ==========================================================
    // fill bank is the selected one
    assign wr_addr = {bank_sel_r, line_cnt_r, unit_cnt_r};
    assign rd_addr = {~bank_sel_r, DISP_LINE, DISP_UNIT};

    // Only the fill bank is ever written and only the display bank
    // is ever read, so the two sides never meet on one unit.
    // sixteen 48-bit units a line
    // whole unit kept, red in the low bits
    always_ff @(posedge CLOCK) begin
        if (gs_write) begin
            mem_r[wr_addr] <= fifo_out_data[UNIT_W-1:0];
        end
    end

    // Display side always reads the other bank. A unit never
    // written reads as unknown; reset clears only the output
    // register, since clearing every unit would need a wide reset.
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            disp_data_r <= '0;
        end else begin
            disp_data_r <= mem_r[rd_addr];
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = dat_o_r;
    assign DISP_DATA = disp_data_r;
endmodule // double_bank_grayscale_memory

// ===== src/gs_memory_pkg.sv
package gs_memory_pkg;
    // ==========================================================
    // Register map (byte addresses, one 32-bit word each)
    // ==========================================================
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_SHIFT_LO = 8'h04;
    localparam logic [7:0] OFS_SHIFT_HI = 8'h08;
    localparam logic [7:0] OFS_CONFIG0 = 8'h0c;
    localparam logic [7:0] OFS_CONTROL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // ==========================================================
    // Command identifiers
    // ==========================================================
    localparam logic [15:0] CMD_GS_WRITE = 16'haa30;
    localparam logic [15:0] CMD_FRAME_SYNC = 16'haaf0;

    // ==========================================================
    // Field layout
    // ==========================================================
    localparam int SCAN_NUM_LSB = 16;
    localparam int SCAN_NUM_MSB = 21;
    localparam int STAT_LINE_LSB = 8;
    localparam int STAT_NONEMPTY_BIT = 16;
    localparam int STAT_READY_BIT = 17;
    localparam int CTRL_HOLD_BIT = 0;
    localparam int RED_LSB = 0;
    localparam int GREEN_LSB = 16;
    localparam int BLUE_LSB = 32;

    // ==========================================================
    // Geometry
    // ==========================================================
    localparam int UNIT_W = 48;
    localparam int UNITS_PER_LINE = 16;
    localparam int LINES = 64;
    localparam int BANKS = 2;
    localparam int UNIT_AW = 4;
    localparam int LINE_AW = 6;
    localparam int MEM_AW = 1 + LINE_AW + UNIT_AW;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_W = UNIT_W + 1;
    localparam logic [UNIT_AW-1:0] LAST_UNIT = 4'hf;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [5:0] SCAN_NUM_RST = 6'h3f;
    localparam logic BANK_SEL_RST = 1'b0;
endpackage

// ===== bench/gs_mem_checker_assertions.sv
`timescale 1ns/1ps
// ==============================================================
// Bus and display port checks
module gs_mem_checker
    import gs_memory_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic [LINE_AW-1:0] DISP_LINE,
    input wire logic [UNIT_AW-1:0] DISP_UNIT,
    input wire logic [UNIT_W-1:0] DISP_DATA
);
    // All checks but a_reset_quiet sleep while reset is low
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic req;
    logic rd;
    // New request, not yet acked (a held-off command too), and new read
    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign rd = req && !WB_WE_I;
    a_ack_prompt: assert property (
        req && WB_ADR_I != OFS_COMMAND |=> WB_ACK_O)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (
        WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
    a_ack_idle: assert property (
        !(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O) else $error("stray ack");
    a_unmapped_zero: assert property (
        rd && WB_ADR_I > OFS_STATUS |=> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (
        !rd |=> $stable(WB_DAT_O)) else $error("read data moved");
    a_shift_top: assert property (
        rd && WB_ADR_I == OFS_SHIFT_HI |=> WB_DAT_O[31:16] == 16'h0)
        else $error("upper shift half not zero");
    a_status_spare: assert property (
        rd && WB_ADR_I == OFS_STATUS
        |=> WB_DAT_O[31:18] == 14'h0 && WB_DAT_O[7:4] == 4'h0)
        else $error("status spare bits set");
    a_reset_quiet: assert property (disable iff (1'b0)
        !RST_N |-> !WB_ACK_O && WB_DAT_O == 32'h0 && DISP_DATA == 48'h0)
        else $error("outputs active in reset");
endmodule // gs_mem_checker

bind double_bank_grayscale_memory gs_mem_checker chk_i (.CLOCK, .RST_N,
    .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .DISP_LINE, .DISP_UNIT, .DISP_DATA);

// ===== bench/gs_ctrl_model.sv
`timescale 1ns/1ps
// ==============================================================
// Display controller model on the register bus
module gs_ctrl_model
    import gs_memory_pkg::*;
(
    input wire logic clk,
    input wire logic ack,
    input wire logic [31:0] rdat,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [7:0] adr,
    output logic [3:0] sel,
    output logic [31:0] wdat,
    output logic tmo
);
    // Idle bus from time zero
    initial {cyc, stb, we, adr, sel, wdat, tmo} = '0;
    // Request held whole until ack is sampled; a lost ack ends the run
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 100);
        q = rdat;
        tmo <= (ack !== 1'b1);
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic cmd(input logic [15:0] id);
        logic [31:0] q;
        xfer(1'b1, OFS_COMMAND, {16'h0, id}, q);
    endtask
    task automatic unit(input logic [47:0] u);
        logic [31:0] q;
        xfer(1'b1, OFS_SHIFT_LO, u[31:0], q);
        xfer(1'b1, OFS_SHIFT_HI, {16'h0, u[47:32]}, q);
        cmd(CMD_GS_WRITE);
    endtask
endmodule // gs_ctrl_model

// ===== bench/tb_double_bank_grayscale_memory.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
// ==============================================================
// Bench with a queue-free reference of banks and counters
module tb_double_bank_grayscale_memory
    import gs_memory_pkg::*;
;
    logic CLOCK;
    logic RST_N;
    logic cyc, stb, we, ack, tmo;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [5:0] dl;
    logic [3:0] du;
    logic [47:0] dd;
    logic [47:0] mem[int];
    logic [47:0] last;
    logic [31:0] s = 32'h12;
    int n_mismatch = 0, n_tests = 0, flag = 0, line = 0, unit = 0;
    double_bank_grayscale_memory double_bank_grayscale_memory_i (.CLOCK,
        .RST_N, .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .DISP_LINE(dl), .DISP_UNIT(du), .DISP_DATA(dd));
    gs_ctrl_model gs_ctrl_model_i (.clk(CLOCK), .ack, .rdat, .cyc, .stb,
        .we, .adr, .sel, .wdat, .tmo);
    // Free-running device clock
    initial begin
        CLOCK = 1'b0;
        forever #25 CLOCK = ~CLOCK;
    end
    function automatic logic [31:0] xs();
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // Two draws make one 48-bit unit, the low word from the second
    function automatic logic [47:0] rnd48();
        logic [31:0] a;
        logic [31:0] b;
        a = xs();
        b = xs();
        return {a[15:0], b};
    endfunction
    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // A lost ack counts against the run and closes it
    always @(posedge tmo) begin
        n_mismatch++;
        results();
    end
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        gs_ctrl_model_i.xfer(1'b0, a, 32'h0, q);
        `CHK("read", e, q)
    endtask
    // Poll until the queue drains, then compare both counters
    task automatic settle();
        int n;
        n = 0;
        do begin
            gs_ctrl_model_i.xfer(1'b0, OFS_STATUS, 32'h0, q);
            n++;
        end while (q[16] !== 1'b0 && n < 50);
        `CHK("status", {16'h2, 2'b0, 6'(line), 4'h0, 4'(unit)}, q)
    endtask
    // reference write and counter steps (scan field 1)
    task automatic put(input logic [47:0] v);
        gs_ctrl_model_i.unit(v);
        last = v;
        mem[flag * 1024 + line * 16 + unit] = v;
        unit = (unit + 1) % 16;
        if (unit == 0) line = (line == 1) ? 0 : line + 1;
    endtask
    // Display side reads every written unit of the shown bank
    task automatic show();
        for (int k = 0; k < 32; k++) begin
            if (mem.exists((1 - flag) * 1024 + k)) begin
                @(posedge CLOCK);
                dl <= 6'(k / 16);
                du <= 4'(k % 16);
                repeat (2) @(posedge CLOCK);
                `CHK("disp", mem[(1 - flag) * 1024 + k], dd)
            end
        end
    endtask
    initial begin
        RST_N <= 1'b0;
        dl = 6'h0;
        du = 4'h0;
        repeat (16) @(posedge CLOCK);
        RST_N <= 1'b1;
        rdchk(OFS_CONFIG0, 32'h003f0000);
        settle();
        gs_ctrl_model_i.xfer(1'b1, 8'h40, 32'hffffffff, q);
        rdchk(8'h40, 32'h0);
        gs_ctrl_model_i.xfer(1'b1, OFS_CONFIG0, 32'h00010000, q);
        gs_ctrl_model_i.xfer(1'b1, OFS_CONTROL, 32'h1, q);
        for (int k = 0; k < 34; k++) begin
            put(rnd48());
            if (k == 7) begin
                rdchk(OFS_STATUS, 32'h00010000);
                gs_ctrl_model_i.xfer(1'b1, OFS_CONTROL, 32'h0, q);
            end
            if (k > 7) settle();
        end
        gs_ctrl_model_i.cmd(16'haa31);
        settle();
        gs_ctrl_model_i.cmd(CMD_FRAME_SYNC);
        flag = 1;
        settle();
        show();
        put(rnd48());
        put(rnd48());
        rdchk(OFS_SHIFT_LO, last[31:0]);
        rdchk(OFS_SHIFT_HI, {16'h0, last[47:32]});
        rdchk(OFS_CONTROL, 32'h0);
        gs_ctrl_model_i.cmd(CMD_FRAME_SYNC);
        flag = 0;
        settle();
        show();
        results();
    end
endmodule // tb_double_bank_grayscale_memory
